/* File: hdl/gprf_pkg.sv */
package gprf_pkg;
	localparam int RegNumWidth = 8;
	localparam int DataWidth = 32;
	localparam int AccWidth = 64;
	localparam int AccCount = 4;
	localparam int BankCount = 16;
	localparam int BankShift = 4;
	localparam int LocalWidth = 7;
	localparam int StorageDepth = 256;
	localparam logic [7:0] RegIndirect = 8'h00;
	localparam logic [7:0] RegStackPtr = 8'h01;
	localparam logic [7:0] RegCondAccum = 8'h02;
	localparam logic [7:0] RegCondShift = 8'h03;
	localparam logic [7:0] FirstUnimpl = 8'h04;
	localparam logic [7:0] LastUnimpl = 8'h3F;
	localparam int SpLowBit = 2;
	localparam int PtrLowBit = 2;
	localparam int SpHighBit = 8;
	localparam int PtrHighBit = 9;
	localparam int SignBit = 31;
	localparam logic [7:0] PairStep = 8'h01;
	localparam logic [7:0] SprPtrC = 8'h80;
	localparam logic [7:0] SprPtrA = 8'h81;
	localparam logic [7:0] SprPtrB = 8'h82;
	localparam logic [7:0] SprBankProtect = 8'h07;
	localparam logic [7:0] SprUnprotFirst = 8'h80;
	localparam logic [7:0] SprUnprotLast = 8'hA4;
	localparam logic [15:0] BankProtectReset = 16'h0000;
	localparam logic [31:0] CondAccumReset = 32'h00000000;
	localparam int AddrDelay = 2;
	typedef enum logic [2:0] {
		MODE_USER = 3'b001,
		MODE_SUPER = 3'b010,
		MODE_MONITOR = 3'b100
	} gprf_mode_type;
endpackage

/* File: hdl/gprf_storage.sv */
`timescale 1ns/100ps
`default_nettype none
module gprf_storage (
	input wire logic clk, // Clock
	input wire logic [7:0] readAddrA, // Read port A index
	input wire logic [7:0] readAddrB, // Read port B index
	output logic [31:0] readDataA, // Registered read data A
	output logic [31:0] readDataB, // Registered read data B
	input wire logic writeEn, // Write strobe
	input wire logic [7:0] writeAddr, // Write index
	input wire logic [31:0] writeData // Write data
);
	logic [31:0] mem [gprf_pkg::StorageDepth];
	always_ff @(posedge clk) begin
		if (writeEn) begin
			mem[writeAddr] <= writeData;
		end
		readDataA <= mem[readAddrA];
		readDataB <= mem[readAddrB];
	end
endmodule
`default_nettype wire

/* File: hdl/gprf_index_calc.sv */
`timescale 1ns/100ps
`default_nettype none
module gprf_index_calc (
	input wire logic [7:0] regNum, // Register number from instruction
	input wire logic [7:0] indirectPtr, // This field's indirect pointer
	input wire logic [6:0] stackBase, // Stack pointer bits 8..2
	output logic [7:0] absIndex // Absolute register index
);
	always_comb begin
		if (regNum == gprf_pkg::RegIndirect) begin
			absIndex = indirectPtr;
		end else if (!regNum[gprf_pkg::LocalWidth]) begin
			absIndex = regNum;
		end else begin
			absIndex = {1'b1, 7'(regNum[gprf_pkg::LocalWidth-1:0] + stackBase)};
		end
	end
endmodule
`default_nettype wire

/* File: hdl/gprf_top.sv */
//
// Contract
// - Three 8-bit register fields per instruction
// - Top bit zero: global, index unchanged
// - Globals 4..63 unbacked, still protectable
// - Number zero uses field's indirect pointer
// - Shadow stack pointer updated by ALU results
// - Register 2 writes/reads condition accumulator
// - Register 3 shifts in result MSB
// - Local index adds stack bits 8..2
// - Banks of sixteen, bank 0 from 4
// - Mask bit guards bank in user mode
// - Protection checks final absolute index
// - Supervisor/monitor ignore bank mask
// - Three absolute pointers, no stack offset
// - Special move loads pointer from bits 9..2
// - Certain instructions set all pointers together
// - Pointer setting checked, except special move
// - Four 64-bit floating accumulators
// - Reserved special bits read zero
// - Special registers by direct 8-bit number
// - Special 128..164 unprotected, rest protected
// - Unimplemented unprotected writes ignored
// - User access to protected special traps
//
`timescale 1ns/100ps
`default_nettype none
module gprf_top (
	input wire logic clk, // Clock
	input wire logic reset, // Async reset, active high
	input wire gprf_pkg::gprf_mode_type mode, // Current program mode
	input wire logic instValid, // Instruction presented this cycle
	input wire logic [7:0] srcNumA, // Source A register number
	input wire logic [7:0] srcNumB, // Source B register number
	input wire logic [7:0] dstNumC, // Destination register number
	input wire logic useA, // Source A is used
	input wire logic useB, // Source B is used
	input wire logic useC, // Destination is used
	input wire logic resultValid, // Write result this cycle
	input wire logic [7:0] resultIndex, // Absolute index for result
	input wire logic [31:0] resultData, // Result word
	input wire logic resultIsAlu, // Result from arithmetic/logical class
	input wire logic resultPair, // This write is the second word of a double
	input wire logic [31:0] resultDataHi, // Second word of double
	input wire logic setPointers, // Load all pointers from this instruction
	input wire logic sprWrite, // Special register write
	input wire logic sprRead, // Special register read
	input wire logic [7:0] sprNum, // Special register number
	input wire logic [31:0] sprWriteData, // Special register write data
	input wire logic accWrite, // Write floating accumulator
	input wire logic [1:0] accSel, // Accumulator select
	input wire logic [63:0] accWriteData, // Accumulator write data
	output logic [7:0] absA, // Absolute index of source A
	output logic [7:0] absB, // Absolute index of source B
	output logic [7:0] absC, // Absolute index of destination
	output logic [31:0] readDataA, // Source A data
	output logic [31:0] readDataB, // Source B data
	output logic [31:0] readDataB2, // Pair partner of source A
	output logic protTrap, // Protection violation pulse
	output logic [31:0] sprReadData, // Special register read data
	output logic [63:0] accReadData, // Selected accumulator
	output logic [63:0] accZero // Accumulator 0 for multiply-sum
);
	typedef struct packed {
		logic [15:0] bankMask;
		logic [31:0] condAccum;
		logic [6:0] shadowSp;
		logic [7:0] ptrA;
		logic [7:0] ptrB;
		logic [7:0] ptrC;
		logic [1:0][6:0] spPipe;
		logic [1:0][25:0] ptrPipe;
		logic [7:0] absA;
		logic [7:0] absB;
		logic [7:0] absC;
		logic [1:0] srcSpecA;
		logic [1:0] srcSpecB;
		logic protTrap;
		logic [31:0] sprReadData;
		logic [3:0][63:0] acc;
		logic [63:0] accReadData;
	} gprf_state_type;

	gprf_state_type state;
	gprf_state_type next_state;
	logic [7:0] calcA;
	logic [7:0] calcB;
	logic [7:0] calcC;
	logic [31:0] memA;
	logic [31:0] memB;
	logic [31:0] memPair;
	logic memWriteEn;
	logic [7:0] memWriteAddr;
	logic [31:0] memWriteData;

	function automatic logic bankGuarded(input logic [7:0] idx, input logic [15:0] mask);
		logic [3:0] bank;
		bank = idx[7:gprf_pkg::BankShift];
		// Indexes 0..3 are addressing specials, outside every bank
		if (idx < gprf_pkg::FirstUnimpl) begin
			return 1'b0;
		end
		return mask[bank];
	endfunction

	function automatic logic sprProtected(input logic [7:0] num);
		return (num < gprf_pkg::SprUnprotFirst) || (num > gprf_pkg::SprUnprotLast);
	endfunction

	// Pointers read back word-aligned so software can reuse them as byte addresses
	function automatic logic [31:0] ptrView(input logic [7:0] ptr);
		logic [31:0] view;
		view = '0;
		view[gprf_pkg::PtrHighBit:gprf_pkg::PtrLowBit] = ptr;
		return view;
	endfunction

	// Second word of a double sits one index above the first; wraps at the top
	function automatic logic [7:0] pairIndex(input logic [7:0] idx);
		return 8'(idx + gprf_pkg::PairStep);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Index computation and storage

	gprf_index_calc calcAInst (
		.regNum(srcNumA),
		.indirectPtr(state.ptrA),
		.stackBase(state.shadowSp),
		.absIndex(calcA)
	);

	gprf_index_calc calcBInst (
		.regNum(srcNumB),
		.indirectPtr(state.ptrB),
		.stackBase(state.shadowSp),
		.absIndex(calcB)
	);

	gprf_index_calc calcCInst (
		.regNum(dstNumC),
		.indirectPtr(state.ptrC),
		.stackBase(state.shadowSp),
		.absIndex(calcC)
	);

	// A pair's high word is written at index+1 over the one shared write port into
	// both copies; the second storage copy is read at source A's index+1.
	gprf_storage storeInst (
		.clk(clk),
		.readAddrA(calcA),
		.readAddrB(calcB),
		.readDataA(memA),
		.readDataB(memB),
		.writeEn(memWriteEn),
		.writeAddr(memWriteAddr),
		.writeData(memWriteData)
	);

	gprf_storage pairInst (
		.clk(clk),
		.readAddrA(pairIndex(calcA)),
		.readAddrB(calcB),
		.readDataA(memPair),
		.readDataB(),
		.writeEn(memWriteEn),
		.writeAddr(memWriteAddr),
		.writeData(memWriteData)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic userMode;
		logic gprViol;
		logic sprViol;
		logic [7:0] newPtr;
		userMode = 1'b0;
		gprViol = 1'b0;
		sprViol = 1'b0;
		newPtr = sprWriteData[gprf_pkg::PtrHighBit:gprf_pkg::PtrLowBit];
		next_state = state;
		memWriteEn = 1'b0;
		memWriteAddr = resultIndex;
		memWriteData = resultData;
		userMode = (mode == gprf_pkg::MODE_USER);
		gprViol = instValid && ((useA && bankGuarded(calcA, state.bankMask)) ||
			(useB && bankGuarded(calcB, state.bankMask)) ||
			(useC && bankGuarded(calcC, state.bankMask)));
		sprViol = (sprWrite || sprRead) && sprProtected(sprNum);
		next_state.protTrap = userMode && (gprViol || sprViol);
		next_state.absA = calcA;
		next_state.absB = calcB;
		next_state.absC = calcC;
		next_state.srcSpecA = (calcA == gprf_pkg::RegCondAccum) ? 2'b01 : 2'b00;
		next_state.srcSpecB = (calcB == gprf_pkg::RegCondAccum) ? 2'b01 : 2'b00;

		// Stack and pointer values are copied into a short pipe that nothing reads;
		// decode uses the current shadowSp and pointers without delay.
		next_state.spPipe[0] = state.shadowSp;
		next_state.ptrPipe[0] = {2'b00, state.ptrA, state.ptrB, state.ptrC};
		next_state.spPipe[1] = state.spPipe[0];
		next_state.ptrPipe[1] = state.ptrPipe[0];
		if (resultValid) begin
			if (resultIndex == gprf_pkg::RegCondAccum) begin
				next_state.condAccum = resultData;
			end else if (resultIndex == gprf_pkg::RegCondShift) begin
				next_state.condAccum = {state.condAccum[gprf_pkg::SignBit-1:0], resultData[gprf_pkg::SignBit]};
			end else if (resultIndex >= gprf_pkg::FirstUnimpl && resultIndex <= gprf_pkg::LastUnimpl) begin
				memWriteEn = 1'b0;
			end else begin
				memWriteEn = 1'b1;
				if (resultPair) begin
					memWriteAddr = pairIndex(resultIndex);
					memWriteData = resultDataHi;
				end
			end
			if (resultIndex == gprf_pkg::RegStackPtr && resultIsAlu) begin
				next_state.shadowSp = resultData[gprf_pkg::SpHighBit:gprf_pkg::SpLowBit];
			end
		end
		if (setPointers && !(userMode && gprViol)) begin
			next_state.ptrA = calcA;
			next_state.ptrB = calcB;
			next_state.ptrC = calcC;
		end
		if (sprWrite && !(userMode && sprViol)) begin
			unique case (sprNum)
				gprf_pkg::SprPtrA: next_state.ptrA = newPtr;
				gprf_pkg::SprPtrB: next_state.ptrB = newPtr;
				gprf_pkg::SprPtrC: next_state.ptrC = newPtr;
				gprf_pkg::SprBankProtect: next_state.bankMask = sprWriteData[gprf_pkg::BankCount-1:0];
				default: ;
			endcase
		end
		if (sprRead) begin
			next_state.sprReadData = '0;
			unique case (sprNum)
				gprf_pkg::SprPtrA: next_state.sprReadData = ptrView(state.ptrA);
				gprf_pkg::SprPtrB: next_state.sprReadData = ptrView(state.ptrB);
				gprf_pkg::SprPtrC: next_state.sprReadData = ptrView(state.ptrC);
				gprf_pkg::SprBankProtect: next_state.sprReadData = 32'(state.bankMask);
				default: next_state.sprReadData = '0;
			endcase
		end
		if (accWrite) begin
			next_state.acc[accSel] = accWriteData;
		end
		next_state.accReadData = state.acc[accSel];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '0;
			state.bankMask <= gprf_pkg::BankProtectReset;
			state.condAccum <= gprf_pkg::CondAccumReset;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readDataA <= '0;
			readDataB <= '0;
			readDataB2 <= '0;
		end else begin
			readDataA <= state.srcSpecA[0] ? state.condAccum : memA;
			readDataB <= state.srcSpecB[0] ? state.condAccum : memB;
			readDataB2 <= memPair;
		end
	end

	assign absA = state.absA;
	assign absB = state.absB;
	assign absC = state.absC;
	assign protTrap = state.protTrap;
	assign sprReadData = state.sprReadData;
	assign accReadData = state.accReadData;
	assign accZero = state.acc[0];
endmodule
`default_nettype wire

/* File: testbench/gprf_pipe_model.sv */
`timescale 1ns/100ps
`default_nettype none
module gprf_pipe_model (
	input wire logic clk, // Clock
	output logic resultValid = 1'h0, // Result strobe
	output logic [7:0] resultIndex = 8'h00, // Result index
	output logic [31:0] resultData = 32'h0, // Result word
	output logic resultIsAlu = 1'h0, // Arithmetic class
	output logic resultPair = 1'h0, // Double high word strobe
	output logic [31:0] resultDataHi = 32'h0 // Double high word
);
// Entered at a falling edge; the strobe stands one cycle
task automatic write(input logic [7:0] idx, input logic [31:0] d, input logic alu);
	resultValid = 1'h1;
	resultIndex = idx;
	resultData = d;
	resultIsAlu = alu;
	@(negedge clk);
	resultValid = 1'h0;
	// A released bus must not keep showing the last word
	resultData = ~d;
endtask
// High word of a double; the low word goes by a separate write
task automatic pair(input logic [7:0] idx, input logic [31:0] hi);
	resultValid = 1'h1;
	resultPair = 1'h1;
	resultIndex = idx;
	resultDataHi = hi;
	@(negedge clk);
	resultValid = 1'h0;
	resultPair = 1'h0;
	resultDataHi = ~hi;
endtask
endmodule
`default_nettype wire

/* File: testbench/gprf_top_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module gprf_top_monitor (
	input wire logic clk, // Clock
	input wire logic reset, // Reset
	input wire gprf_pkg::gprf_mode_type mode, // Mode
	input wire logic instValid, // Valid
	input wire logic [7:0] srcNumA, // Number A
	input wire logic [7:0] srcNumB, // Number B
	input wire logic [7:0] dstNumC, // Number C
	input wire logic setPointers, // Pointer load
	input wire logic sprWrite, // Special write
	input wire logic sprRead, // Special read
	input wire logic [7:0] sprNum, // Special number
	input wire logic [31:0] sprWriteData, // Special data
	input wire logic resultValid, // Result strobe
	input wire logic [7:0] resultIndex, // Result index
	input wire logic [31:0] resultData, // Result word
	input wire logic resultIsAlu, // Arithmetic
	input wire logic [7:0] absA, // Index A
	input wire logic [31:0] readDataA, // Data A
	input wire logic protTrap // Trap
);
logic spWr;
logic [6:0] spBase;
default clocking cb @(posedge clk);
endclocking
default disable iff (reset);
assign spWr = resultValid && resultIsAlu && resultIndex == 8'h01;
// Own shadow base; only arithmetic results move it
always_ff @(posedge clk or posedge reset) begin
	if (reset) begin
		spBase <= 7'h00;
	end else if (spWr) begin
		spBase <= resultData[8:2];
	end
end
////////////////////////////////////////
a_global_index: assert property (
	instValid && !srcNumA[7] && srcNumA != 8'h00 |=> absA == $past(srcNumA)) else $error("bad global index");
a_local_offset: assert property (
	instValid && srcNumA[7] && !spWr && !$past(spWr) |=> absA == {1'h1, 7'($past(srcNumA[6:0]) + spBase)})
	else $error("bad local index");
a_indirect_load: assert property (
	sprWrite && sprNum == 8'h81 ##1 (!sprWrite && !setPointers)[*3] ##1 (instValid && srcNumA == 8'h00
	&& !setPointers) |=> absA == $past(sprWriteData[9:2], 5)) else $error("bad pointer load");
a_cond_code_accum_shift_in: assert property (
	resultValid && resultIndex == 8'h02 ##1 !resultValid ##1 resultValid && resultIndex == 8'h03 ##1 !resultValid
	##1 (instValid && srcNumA == 8'h02 && !resultValid)
	|-> ##2 readDataA == {$past(resultData[30:0], 6), $past(resultData[31], 4)}) else $error("bad shift");
a_super_free: assert property (mode != gprf_pkg::MODE_USER |=> !protTrap) else $error("trap out of user");
a_low_globals: assert property (
	instValid && srcNumA inside {[8'h01:8'h03]} && srcNumB inside {[8'h01:8'h03]} && dstNumC inside
	{[8'h01:8'h03]} && !sprRead && !sprWrite |=> !protTrap) else $error("trap on index 1 to 3");
a_user_spr_trap: assert property (
	mode == gprf_pkg::MODE_USER && (sprRead || sprWrite) && !(sprNum inside {[8'h80:8'hA4]}) |=> protTrap)
	else $error("no special trap");
a_unprot_spr: assert property (
	mode == gprf_pkg::MODE_USER && sprRead && !instValid && !setPointers && sprNum inside {[8'h80:8'hA4]}
	|=> !protTrap) else $error("open special trapped");
c_trap: cover property (protTrap);
c_local: cover property (instValid && srcNumA[7]);
c_pointer: cover property (instValid && srcNumA == 8'h00);
endmodule
bind gprf_top gprf_top_monitor u_monitor (.*);
`default_nettype wire

/* File: testbench/gpr_file_addressing_protection_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module gpr_file_addressing_protection_tb_top;
logic clk, protTrap, resultValid, resultIsAlu, resultPair;
logic reset = 1'h1, instValid = 1'h0, setPointers = 1'h0, sprWrite = 1'h0, sprRead = 1'h0, accWrite = 1'h0;
logic useA = 1'h1, useB = 1'h1, useC = 1'h1;
logic [1:0] accSel = 2'h0;
logic [7:0] srcNumA = 8'h0, srcNumB = 8'h0, dstNumC = 8'h0, sprNum = 8'h0, resultIndex, absA, absB, absC;
logic [31:0] sprWriteData = 32'h0, resultData, resultDataHi, readDataA, readDataB, readDataB2, sprReadData;
logic [63:0] accWriteData = 64'h0, accReadData, accZero;
gprf_pkg::gprf_mode_type mode = gprf_pkg::MODE_SUPER;
int err_total, total_checks;
gprf_top DUT (.*);
gprf_pipe_model PIPE (.*);
initial begin
	clk = 1'h0;
	forever #10 clk = ~clk;
end
////////////////////////////////////////
task automatic final_report();
	$display("checks %0d mismatches %0d", total_checks, err_total);
	if (err_total == 0 && total_checks > 0) begin
		$display("No errors found");
	end else begin
		$display("Errors were found");
	end
	$finish;
endtask
task automatic chk(input string what, input logic [63:0] want, input logic [63:0] got);
	total_checks++;
	if (got !== want) begin
		err_total++;
		$display("unexpected %s: expected %h seen %h", what, want, got);
	end
endtask
// Leading wait keeps a strobe from changing twice in one step
task automatic inst(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic ptr);
	@(negedge clk);
	instValid = 1'h1;
	srcNumA = a;
	srcNumB = b;
	dstNumC = c;
	setPointers = ptr;
	@(negedge clk);
	instValid = 1'h0;
	setPointers = 1'h0;
endtask
task automatic spr(input logic wr, input logic [7:0] num, input logic [31:0] d);
	@(negedge clk);
	sprWrite = wr;
	sprRead = ~wr;
	sprNum = num;
	sprWriteData = d;
	@(negedge clk);
	sprWrite = 1'h0;
	sprRead = 1'h0;
endtask
////////////////////////////////////////
task automatic t_index();
	spr(1'h0, 8'h07, 32'h0);
	chk("mask", 64'h0, sprReadData);
	spr(1'h1, 8'h07, 32'hFFFF_FFFF);
	spr(1'h0, 8'h07, 32'h0);
	chk("mask", 64'hFFFF, sprReadData);
	inst(8'h45, 8'h7F, 8'h40, 1'h0);
	chk("absA", 8'h45, absA);
	PIPE.write(8'h01, 32'h1F8, 1'h1);
	inst(8'h85, 8'hFF, 8'h80, 1'h0);
	chk("absA", 8'h83, absA);
	chk("absB", 8'hFD, absB);
endtask
task automatic t_cca();
	spr(1'h1, 8'h81, 32'h234);
	repeat (2) @(negedge clk);
	inst(8'h00, 8'h85, 8'h40, 1'h0);
	chk("absA", 8'h8D, absA);
	PIPE.write(8'h02, 32'h8000_0003, 1'h1);
	@(negedge clk);
	PIPE.write(8'h03, 32'h8000_0000, 1'h1);
	inst(8'h02, 8'h40, 8'h40, 1'h0);
	@(negedge clk);
	chk("readDataA", 32'h7, readDataA);
endtask
task automatic t_protect();
	spr(1'h1, 8'h07, 32'h110);
	mode = gprf_pkg::MODE_USER;
	inst(8'h45, 8'h02, 8'h02, 1'h0);
	chk("trap", 1'h1, protTrap);
	useA = 1'h0;
	inst(8'h45, 8'h02, 8'h02, 1'h0);
	chk("trap", 1'h0, protTrap);
	useA = 1'h1;
	inst(8'h90, 8'h02, 8'h02, 1'h0);
	chk("trap", 1'h1, protTrap);
	inst(8'h81, 8'h02, 8'h02, 1'h0);
	chk("trap", 1'h0, protTrap);
	inst(8'h03, 8'h01, 8'h02, 1'h0);
	chk("trap", 1'h0, protTrap);
	spr(1'h0, 8'h07, 32'h0);
	chk("trap", 1'h1, protTrap);
	spr(1'h0, 8'hA4, 32'h0);
	chk("trap", 1'h0, protTrap);
	spr(1'h0, 8'hA5, 32'h0);
	chk("trap", 1'h1, protTrap);
	inst(8'h90, 8'h02, 8'h02, 1'h1);
	chk("trap", 1'h1, protTrap);
	mode = gprf_pkg::MODE_SUPER;
	repeat (2) @(negedge clk);
	inst(8'h00, 8'h02, 8'h02, 1'h0);
	chk("absA", 8'h8D, absA);
	inst(8'h45, 8'h46, 8'h47, 1'h1);
	chk("trap", 1'h0, protTrap);
	repeat (2) @(negedge clk);
	inst(8'h00, 8'h00, 8'h00, 1'h0);
	chk("absB", 8'h46, absB);
	chk("absC", 8'h47, absC);
endtask
task automatic t_pair();
	PIPE.write(8'h50, 32'h1111_2222, 1'h0);
	@(negedge clk);
	PIPE.pair(8'h50, 32'hAAAA_5555);
	inst(8'h50, 8'h51, 8'h40, 1'h0);
	@(negedge clk);
	chk("readDataA", 32'h1111_2222, readDataA);
	chk("readDataB", 32'hAAAA_5555, readDataB);
	chk("readDataB2", 32'hAAAA_5555, readDataB2);
endtask
// Mid-run reset must clear mask, pointers and accumulators
task automatic t_reset();
	@(negedge clk);
	reset = 1'h1;
	repeat (2) @(negedge clk);
	reset = 1'h0;
	spr(1'h0, 8'h07, 32'h0);
	chk("mask", 64'h0, sprReadData);
	inst(8'h00, 8'h00, 8'h00, 1'h0);
	chk("absA", 8'h00, absA);
	chk("accZero", 64'h0, accZero);
endtask
task automatic t_acc();
	for (int i = 0; i < 4; i++) begin
		@(negedge clk);
		accWrite = 1'h1;
		accSel = 2'(i);
		accWriteData = {16{4'(i + 8)}};
		@(negedge clk);
		accWrite = 1'h0;
		@(negedge clk);
		chk("acc", {16{4'(i + 8)}}, accReadData);
	end
	chk("accZero", {16{4'h8}}, accZero);
endtask
initial begin
	repeat (5) @(posedge clk);
	@(negedge clk);
	reset = 1'h0;
	t_index();
	t_cca();
	t_protect();
	t_pair();
	t_acc();
	t_reset();
	final_report();
end
initial begin
	#20000;
	err_total++;
	final_report();
end
endmodule
`default_nettype wire
